// ===== common/afrs_regs.vh
// constants of the frame readout and alignment block
// assumes a single inclusion point per compile unit; guarded anyway
`ifndef AFRS_REGS_VH
`define AFRS_REGS_VH

// frame shape
`define AFRS_CHANNELS 4
`define AFRS_WORD_BITS 24

// master clock periods per conversion (plain default)
`define AFRS_MCLK_PER_CONV 1024

// status word field positions
`define AFRS_ST_READY_BIT 0
`define AFRS_ST_OVF_BIT 1
`define AFRS_ST_FLAG_BIT 10

// reset values
`define AFRS_DATA_READY_N_RST 1'b1
`define AFRS_FLAG_RST 1'b0

`endif

// ===== core/afrs_sync.v
// two-flop synchroniser for a group of independent pin levels
// assumes each bit is a slow level or a clock well below clk_i/4
`timescale 1ns/10ps
module afrs_sync #(
   parameter WIDTH = 4
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire [WIDTH-1:0] rst_val_i,
   input wire [WIDTH-1:0] d_i,
   output wire [WIDTH-1:0] q_o
);
   // rst_val_i is used only as a constant tie at the instance
   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;
   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
         always @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               meta_q[g] <= 1'b1;
               sync_q[g] <= 1'b1;
            end else begin
               meta_q[g] <= d_i[g];
               sync_q[g] <= meta_q[g];
            end
         end
      end
   endgenerate
   assign q_o = sync_q ^ (rst_val_i & ~rst_val_i);
endmodule

// ===== core/afrs_core.v
// Function
// - the serial output is released (not driven) whenever chip select is high so devices can share it.
// - results sit in a two-entry buffer and once it overflows data-ready falls only every second conversion.
// - a realign pulse that arrives out of step with the conversion count sets the realign flag even if just cleared.
// - the realign input only checks and restores alignment; it never starts a conversion by itself.
// - a frame that is not clocked out completely is not counted as read and the same result is sent again.
//
// frame readout, two-deep result buffer and alignment check of the converter
// assumes result_i is stable on the clk_i edge where a conversion completes; all pins are asynchronous
`timescale 1ns/10ps
`include "afrs_regs.vh"
module afrs_core #(
   parameter CHANNELS = `AFRS_CHANNELS,
   parameter WORD_BITS = `AFRS_WORD_BITS,
   parameter MCLK_PER_CONV = `AFRS_MCLK_PER_CONV
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire master_clock_in_i,
   input wire realign_n_i,
   input wire cs_n_i,
   input wire sclk_i,
   input wire [CHANNELS*WORD_BITS-1:0] result_i,
   output wire sdo_o,
   output wire sdo_oe_o,
   output wire data_ready_n_o,
   output wire realign_flag_o
);
   // ***********************************************
   // derived sizes
   // ***********************************************
   localparam DW = CHANNELS * WORD_BITS;
   localparam FB = DW + WORD_BITS;
   localparam BCW = $clog2(FB + 1);
   localparam CW = $clog2(MCLK_PER_CONV + 1);
   // end points are cut on purpose to the counter widths; both fit by construction
   localparam integer CONV_LAST_I = MCLK_PER_CONV - 1;
   localparam integer BIT_LAST_I = FB - 1;
   localparam [CW-1:0] CONV_LAST = CONV_LAST_I[CW-1:0];
   localparam [BCW-1:0] BIT_LAST = BIT_LAST_I[BCW-1:0];

   // ***********************************************
   // pin synchronisation
   // ***********************************************
   wire [3:0] pins_s;
   afrs_sync #(
      .WIDTH(4)
   ) u_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .rst_val_i(4'hF),
      .d_i({master_clock_in_i, realign_n_i, cs_n_i, sclk_i}),
      .q_o(pins_s)
   );
   wire mclk_s = pins_s[3];
   wire rl_s = pins_s[2];
   wire cs_s = pins_s[1];
   wire sclk_s = pins_s[0];

   reg [3:0] pins_p_q;
   wire mclk_rise = mclk_s & ~pins_p_q[3];
   wire rl_fall = ~rl_s & pins_p_q[2];
   wire cs_fall = ~cs_s & pins_p_q[1];
   wire sclk_rise = sclk_s & ~pins_p_q[0];
   wire sclk_fall = ~sclk_s & pins_p_q[0];

   // ***********************************************
   // state
   // ***********************************************
   reg [CW-1:0] conv_cnt_q;
   reg [DW-1:0] buf_q [0:1];
   reg rd_idx_q;
   reg [1:0] fill_q;
   reg ov_phase_q;
   reg ovf_q;
   reg flag_q;
   reg data_ready_n_n_q;
   reg refall_q;
   reg [FB-1:0] shift_q;
   reg [BCW-1:0] bit_cnt_q;
   reg in_frame_q;
   reg sdo_q;
   reg sdo_oe_q;

   // ***********************************************
   // event decode
   // ***********************************************
   // out-of-step means the pulse lands anywhere but the period boundary
   wire misalign = rl_fall && (conv_cnt_q != {CW{1'b0}});
   wire conv_tick = mclk_rise && (conv_cnt_q == CONV_LAST) && !misalign;
   wire frame_done = in_frame_q && !cs_s && sclk_fall && (bit_cnt_q == BIT_LAST);
   wire full = (fill_q == 2'd2);
   wire overwrite = conv_tick && full && !frame_done;
   wire push = conv_tick && (!full || frame_done);
   // a full read of an empty buffer still answers, but must not move the pointer or underflow the count
   wire pop = frame_done && (fill_q != 2'd0);
   wire wr_idx = full ? rd_idx_q : (rd_idx_q ^ fill_q[0]);

   wire [WORD_BITS-1:0] status_w;
   assign status_w = ({{(WORD_BITS-1){1'b0}}, flag_q} << `AFRS_ST_FLAG_BIT)
                   | ({{(WORD_BITS-1){1'b0}}, ovf_q} << `AFRS_ST_OVF_BIT)
                   | ({{(WORD_BITS-1){1'b0}}, (fill_q != 2'd0)} << `AFRS_ST_READY_BIT);

   // ***********************************************
   // main process
   // ***********************************************
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pins_p_q <= 4'hF;
         conv_cnt_q <= {CW{1'b0}};
         buf_q[0] <= {DW{1'b0}};
         buf_q[1] <= {DW{1'b0}};
         rd_idx_q <= 1'b0;
         fill_q <= 2'd0;
         ov_phase_q <= 1'b0;
         ovf_q <= 1'b0;
         flag_q <= `AFRS_FLAG_RST;
         data_ready_n_n_q <= `AFRS_DATA_READY_N_RST;
         refall_q <= 1'b0;
         shift_q <= {FB{1'b0}};
         bit_cnt_q <= {BCW{1'b0}};
         in_frame_q <= 1'b0;
         sdo_q <= 1'b0;
         sdo_oe_q <= 1'b0;
      end else begin
         pins_p_q <= pins_s;

         // conversion period counter; realign only restores the phase
         if (misalign) begin
            conv_cnt_q <= {CW{1'b0}};
         end else if (mclk_rise) begin
            conv_cnt_q <= (conv_cnt_q == CONV_LAST) ? {CW{1'b0}} : conv_cnt_q + {{(CW-1){1'b0}}, 1'b1};
         end

         // flag: a set in the clearing cycle wins
         if (misalign) begin
            flag_q <= 1'b1;
         end else if (frame_done) begin
            flag_q <= 1'b0;
         end

         // two-entry buffer
         if (push) begin
            buf_q[wr_idx] <= result_i;
         end else if (overwrite && ov_phase_q) begin
            buf_q[rd_idx_q ^ 1'b1] <= result_i;
         end
         if (pop) begin
            rd_idx_q <= rd_idx_q ^ 1'b1;
         end
         case ({push, pop})
            2'b10: fill_q <= fill_q + 2'd1;
            2'b01: fill_q <= fill_q - 2'd1;
            default: fill_q <= fill_q;
         endcase
         // overflow halves the data-ready rate until a frame drains it
         if (frame_done) begin
            ov_phase_q <= 1'b0;
         end else if (overwrite) begin
            ov_phase_q <= ~ov_phase_q;
         end
         if (overwrite) begin
            ovf_q <= 1'b1;
         end else if (frame_done) begin
            ovf_q <= 1'b0;
         end

         // data-ready: a fresh fall for each new result, high after a full read
         if (refall_q) begin
            refall_q <= 1'b0;
            data_ready_n_n_q <= 1'b0;
         end else if (frame_done) begin
            data_ready_n_n_q <= 1'b1;
            refall_q <= push || (fill_q == 2'd2);
         end else if (push || (overwrite && ov_phase_q)) begin
            if (data_ready_n_n_q) begin
               data_ready_n_n_q <= 1'b0;
            end else begin
               data_ready_n_n_q <= 1'b1;
               refall_q <= 1'b1;
            end
         end

         // serial frame: status word then channel words, msb first
         sdo_oe_q <= !cs_s;
         if (cs_s) begin
            in_frame_q <= 1'b0;
            bit_cnt_q <= {BCW{1'b0}};
         end else if (cs_fall) begin
            // the head entry is resent until a complete frame pops it
            shift_q <= {status_w, buf_q[rd_idx_q]};
            sdo_q <= status_w[WORD_BITS-1];
            in_frame_q <= 1'b1;
            bit_cnt_q <= {BCW{1'b0}};
         end else if (in_frame_q) begin
            if (sclk_rise && (bit_cnt_q != {BCW{1'b0}})) begin
               shift_q <= {shift_q[FB-2:0], 1'b0};
               sdo_q <= shift_q[FB-2];
            end
            if (frame_done) begin
               in_frame_q <= 1'b0;
               bit_cnt_q <= {BCW{1'b0}};
            end else if (sclk_fall) begin
               bit_cnt_q <= bit_cnt_q + {{(BCW-1){1'b0}}, 1'b1};
            end
         end
      end
   end

   assign sdo_o = sdo_q;
   assign sdo_oe_o = sdo_oe_q;
   assign data_ready_n_o = data_ready_n_n_q;
   assign realign_flag_o = flag_q;
endmodule

// ===== verif/afrs_asserts.sv
// pin-level checks of the frame readout block
// assumes one clk_i domain; bound onto every afrs_core
`timescale 1ns/10ps
module afrs_asserts (
   input wire clk_i,
   input wire rst_n_i,
   input wire cs_n_i,
   input wire realign_n_i,
   input wire sdo_oe_o,
   input wire data_ready_n_o,
   input wire realign_flag_o
);
   // ****************
   // properties
   // ****************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_cs_idle; cs_n_i[*5]; endsequence
   sequence s_cs_held; (!cs_n_i)[*5]; endsequence
   property p_oe_off; s_cs_idle |-> !sdo_oe_o; endproperty
   property p_oe_on; s_cs_held |-> sdo_oe_o; endproperty
   property p_oe_cause; $rose(sdo_oe_o) |-> $past(cs_n_i, 2) == 1'b0; endproperty
   property p_flag_cause; $rose(realign_flag_o) |-> !$past(realign_n_i, 2); endproperty
   property p_flag_clear; $fell(realign_flag_o) |-> $past(sdo_oe_o); endproperty
   property p_data_ready_n_hold; $fell(data_ready_n_o) |=> !data_ready_n_o; endproperty
   a_oe_off: assert property (p_oe_off) else $error("sdo driven while deselected");
   a_oe_on: assert property (p_oe_on) else $error("sdo not driven while selected");
   a_oe_cause: assert property (p_oe_cause) else $error("sdo enable without select");
   a_flag_cause: assert property (p_flag_cause) else $error("flag set without realign");
   a_flag_clear: assert property (p_flag_clear) else $error("flag cleared outside frame");
   a_data_ready_n_hold: assert property (p_data_ready_n_hold) else $error("data ready glitch");
endmodule
bind afrs_core afrs_asserts u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .realign_n_i(realign_n_i),
   .sdo_oe_o(sdo_oe_o), .data_ready_n_o(data_ready_n_o), .realign_flag_o(realign_flag_o));

// ===== verif/afrs_spi_host.sv
// spi host stand-in: selects the converter and clocks whole or cut frames
// assumes it is the only select on the line; sclk idles low between frames
`timescale 1ns/10ps
module afrs_spi_host (
   input wire logic clk_i,
   input wire logic sdo_i,
   input wire logic sdo_oe_i,
   output logic cs_n_o,
   output logic sclk_o
);
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
   end
   // ****************
   // frame task
   // ****************
   // a released line reads as unknown, so a late enable shows up as a mismatch
   task automatic frame(input int nbits, output logic [119:0] d);
      d = '0;
      @(posedge clk_i);
      #1 cs_n_o = 1'b0;
      #62.5;
      repeat (nbits) begin
         sclk_o = 1'b1;
         #62.5 sclk_o = 1'b0;
         d = {d[118:0], sdo_oe_i ? sdo_i : 1'bx};
         #62.5;
      end
      // select is released after every frame, so no checksum duty arises
      cs_n_o = 1'b1;
      #62.5;
   endtask
endmodule

// ===== verif/tb_top.sv
// self-checking bench of the frame readout block with a queue model
// assumes the host stand-in and the checker are compiled alongside
`timescale 1ns/10ps
module tb_top;
   logic clk_i = 1'b0, rst_n_i = 1'b0, mclk = 1'b0, realign_n = 1'b1, flg = 1'b0, ovf_m = 1'b0;
   logic [95:0] result = '0;
   logic cs_n, sclk, sdo, sdo_oe, data_ready_n_n, flag;
   logic [119:0] fr;
   logic [95:0] q[$];
   logic ov_ph = 1'b0, data_ready_n_p = 1'b1;
   int n_errors = 0, compares = 0, n_falls = 0;
   always #5 clk_i = ~clk_i;
   // data-ready falls, so each conversion can be held against its expected pulse count
   always @(posedge clk_i) begin
      data_ready_n_p <= data_ready_n_n;
      if (data_ready_n_p && !data_ready_n_n) n_falls <= n_falls + 1;
   end
   // short conversion period keeps the run small
   afrs_core #(.MCLK_PER_CONV(8)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .master_clock_in_i(mclk),
      .realign_n_i(realign_n), .cs_n_i(cs_n), .sclk_i(sclk), .result_i(result), .sdo_o(sdo),
      .sdo_oe_o(sdo_oe), .data_ready_n_o(data_ready_n_n), .realign_flag_o(flag));
   afrs_spi_host host (.clk_i(clk_i), .sdo_i(sdo), .sdo_oe_i(sdo_oe), .cs_n_o(cs_n), .sclk_o(sclk));
   // ****************
   // tasks
   // ****************
   task automatic check(input logic [119:0] seen, input logic [119:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("errors=%0d compares=%0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic edges(input int n);
      repeat (n) begin
         repeat (3) @(posedge clk_i);
         #1 mclk = 1'b1;
         repeat (3) @(posedge clk_i);
         #1 mclk = 1'b0;
      end
      repeat (8) @(posedge clk_i);
   endtask
   task automatic conv;
      int f0;
      bit lands;
      f0 = n_falls;
      #1 result = {$urandom, $urandom, $urandom};
      edges(8);
      // full buffer: one result dropped, the next overwrites the newest entry
      lands = (q.size() < 2) || ov_ph;
      if (q.size() < 2) q.push_back(result);
      else begin
         ovf_m = 1'b1;
         if (ov_ph) q[1] = result;
         ov_ph = !ov_ph;
      end
      check(n_falls - f0, lands);
   endtask
   task automatic read_full(input bit chk);
      host.frame(120, fr);
      check({fr[106], fr[97], fr[96]}, {flg, ovf_m, q.size() != 0});
      if (chk) check(fr[95:0], q[0]);
      if (chk) q.delete(0);
      else q.delete();
      flg = 1'b0;
      ovf_m = 1'b0;
      ov_ph = 1'b0;
      repeat (10) @(posedge clk_i);
      check(flag, 1'b0);
      check(data_ready_n_n, q.size() == 0);
   endtask
   // ****************
   // sequence
   // ****************
   initial begin
      #400us;
      n_errors++;
      complete_run();
   end
   initial begin
      fr = {88'h0, $urandom(54015)};
      repeat (2) @(posedge clk_i);
      #1 rst_n_i = 1'b1;
      repeat (6) @(posedge clk_i);
      check({sdo_oe, data_ready_n_n, flag}, 3'b010);
      conv();
      check(data_ready_n_n, 1'b0);
      read_full(1);
      conv();
      host.frame($urandom_range(1, 119), fr);
      repeat (10) @(posedge clk_i);
      check(data_ready_n_n, 1'b0);
      read_full(1);
      repeat (4) conv();
      read_full(1);
      read_full(1);
      read_full(0);
      for (int k = 0; k < 2; k++) begin
         edges(3);
         #1 realign_n = 1'b0;
         repeat (8) @(posedge clk_i);
         #1 realign_n = 1'b1;
         repeat (8) @(posedge clk_i);
         check(flag, 1'b1);
         flg = 1'b1;
         host.frame(30, fr);
         check(flag, 1'b1);
         result = {$urandom, $urandom, $urandom};
         edges(5);
         check(data_ready_n_n, 1'b1);
         edges(3);
         q.push_back(result);
         check(data_ready_n_n, 1'b0);
         read_full(1);
      end
      complete_run();
   end
endmodule
